/* rtl/tmz_pkg.sv */
package tmz_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_COUNT_LOW = 12'h004;
   localparam logic [11:0] ADDR_HIGH_BUFFER = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h010;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h014;
   localparam logic [11:0] ADDR_CYCLE_DIV = 12'h018;
   // control fields
   localparam int CTL_ON = 7;
   localparam int CTL_NARROW = 6;
   localparam int CTL_SOURCE = 5;
   localparam int CTL_EDGE = 4;
   localparam int CTL_BYPASS = 3;
   localparam int CTL_PS_HI = 2;
   localparam int CTL_PS_LO = 0;
   localparam logic [7:0] CONTROL_RESET = 8'hff;
   localparam logic [7:0] HIGH_BUFFER_RESET = 8'h00;
   localparam logic [7:0] CYCLE_DIV_RESET = 8'h03;
   // increments held off after a count write, in instruction cycles
   localparam logic [1:0] WRITE_HOLDOFF = 2'h2;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

/* rtl/tmz_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser; the first stage feeds only the second
module tmz_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic [STAGES-1:0] chain;

   initial begin
      if (STAGES < 2) $error("tmz_sync needs at least two stages");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], din};
      end
   end

   assign dout = chain[STAGES-1];
endmodule

/* rtl/tmz_timer.sv */
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// [RL1] control bit 7 runs or holds counter
// [RL2] control bit 6 picks 8 or 16 bits
// [RL3] control bit 5 picks pin or cycle clock
// [RL4] control bit 4 set counts falling edges
// [RL5] control bit 3 set bypasses the prescaler
// [RL6] prescale ratio is two shifted by field
// [RL7] bypassed timer mode counts every instruction cycle
// [RL8] count write blocks two instruction cycle increments
// [RL9] pin input synchronised before counting
// [RL10] prescaler is eight bits, never software visible
// [RL11] count write clears assigned prescaler, keeps assignment
// [RL12] assignment may change while running
// [RL13] wrap sets overflow flag; enable gates interrupt
// [RL14] sleep input stops the counter
// [RL15] low byte read copies live high byte; the code skips the copy in narrow mode
// [RL16] low byte write loads high from buffer; the code skips the load in narrow mode
// [RL17] live high byte never directly accessible
// [RL18] narrow mode counts and wraps low byte only
// [RL19] overflow flag sticky until software clears it
module tmz_timer
   import tmz_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // pins and system
   input wire logic EXT_COUNT_INPUT,
   input wire logic SLEEP,
   output logic IRQ
);
   import tmz_pkg::*;

   initial begin
      // one flop alone would let a metastable pin reach the edge detector
      if (SYNC_STAGES < 2) $error("tmz_timer needs at least two sync stages");
   end

   logic [7:0] counter_control;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_live;
   logic [7:0] high_byte_buffer;
   logic [7:0] prescaler_count;
   logic overflow_flag;
   logic overflow_irq_enable;
   logic [7:0] cycle_div;
   logic [7:0] cycle_cnt;
   logic cycle_tick;
   logic [1:0] holdoff;
   logic ext_sync;
   logic ext_prev;
   logic ext_edge;
   logic src_tick;
   logic ps_tick;
   logic inc;
   logic [7:0] ps_mask;
   logic wrap;
   logic [7:0] next_control;
   logic [7:0] next_count_low;
   logic [7:0] next_count_high;
   logic [7:0] next_buffer;
   logic next_flag;
   logic [7:0] next_prescaler;
   logic [1:0] next_holdoff;
   logic [7:0] next_cycle_cnt;
   // data phase state
   logic dp_valid;
   logic dp_write;
   logic [11:0] dp_addr;

   // address phase capture
   logic ap_take;
   assign ap_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else begin
         dp_valid <= ap_take;
         if (ap_take) begin
            dp_write <= HWRITE;
            dp_addr <= HADDR;
         end
      end
   end

   // zero wait states, always okay
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   logic wr_control;
   logic wr_low;
   logic wr_buffer;
   logic wr_clear;
   logic wr_enable;
   logic wr_div;
   logic rd_low;

   // write strobes come from the data phase, when hwdata stands
   function automatic logic hit_write(input logic valid, input logic write,
                                      input logic [11:0] addr, input logic [11:0] target);
      hit_write = valid && write && addr == target;
   endfunction

   assign wr_control = hit_write(dp_valid, dp_write, dp_addr, ADDR_CONTROL);
   assign wr_low = hit_write(dp_valid, dp_write, dp_addr, ADDR_COUNT_LOW);
   assign wr_buffer = hit_write(dp_valid, dp_write, dp_addr, ADDR_HIGH_BUFFER);
   assign wr_clear = hit_write(dp_valid, dp_write, dp_addr, ADDR_IRQ_CLEAR);
   assign wr_enable = hit_write(dp_valid, dp_write, dp_addr, ADDR_IRQ_ENABLE);
   assign wr_div = hit_write(dp_valid, dp_write, dp_addr, ADDR_CYCLE_DIV);
   // read side effect is taken at the address phase so data is ready in the data phase
   assign rd_low = ap_take && !HWRITE && HADDR == ADDR_COUNT_LOW;

   // read data registered from the address phase
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         HRDATA <= '0;
      end else if (ap_take && !HWRITE) begin
         unique case (HADDR)
            ADDR_CONTROL: HRDATA <= {24'h000000, counter_control};
            ADDR_COUNT_LOW: HRDATA <= {24'h000000, count_low_byte};
            ADDR_HIGH_BUFFER: HRDATA <= {24'h000000, high_byte_buffer}; // RL17
            ADDR_IRQ_STATUS: HRDATA <= {31'h00000000, overflow_flag};
            ADDR_IRQ_ENABLE: HRDATA <= {31'h00000000, overflow_irq_enable};
            ADDR_CYCLE_DIV: HRDATA <= {24'h000000, cycle_div};
            default: HRDATA <= '0;
         endcase
      end
   end

   always_comb begin
      next_control = counter_control;
      if (wr_control) begin
         next_control = HWDATA[7:0]; // RL12
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         counter_control <= CONTROL_RESET;
      end else begin
         counter_control <= next_control;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cycle_div <= CYCLE_DIV_RESET;
      end else if (wr_div) begin
         cycle_div <= HWDATA[7:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         overflow_irq_enable <= 1'b0;
      end else if (wr_enable) begin
         overflow_irq_enable <= HWDATA[0];
      end
   end

   // instruction cycle enable: one pulse every cycle_div+1 core clocks
   // the divider paces timer mode and the write holdoff; counter mode runs on pin edges
   always_comb begin
      next_cycle_cnt = cycle_cnt + 8'h01;
      if (cycle_tick) begin
         next_cycle_cnt = '0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cycle_cnt <= '0;
      end else begin
         cycle_cnt <= next_cycle_cnt;
      end
   end
   assign cycle_tick = (cycle_cnt >= cycle_div);

   // pin synchroniser and edge detect
   tmz_sync #(.STAGES(SYNC_STAGES)) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .din(EXT_COUNT_INPUT),
      .dout(ext_sync) // RL9
   );

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_sync;
      end
   end

   // falling when edge bit set, rising otherwise
   assign ext_edge = counter_control[CTL_EDGE] ? (ext_prev && !ext_sync)
                                               : (!ext_prev && ext_sync); // RL4

   // sleep and off both freeze the source
   assign src_tick = counter_control[CTL_ON] && !SLEEP &&
                     (counter_control[CTL_SOURCE] ? ext_edge : cycle_tick); // RL1 RL3 RL14

   function automatic logic [7:0] ratio_mask(input logic [2:0] code);
      ratio_mask = 8'((16'h0002 << code) - 16'h0001);
   endfunction

   assign ps_mask = ratio_mask(counter_control[CTL_PS_HI:CTL_PS_LO]); // RL6
   assign ps_tick = src_tick && ((prescaler_count & ps_mask) == ps_mask);

   // prescaler has no read or write path, only a clear
   // when bypassed the prescaler simply stands still
   always_comb begin
      next_prescaler = prescaler_count;
      if (wr_low && !counter_control[CTL_BYPASS]) begin
         next_prescaler = '0; // RL11
      end else if (src_tick && !counter_control[CTL_BYPASS]) begin
         next_prescaler = prescaler_count + 8'h01; // RL10
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         prescaler_count <= '0;
      end else begin
         prescaler_count <= next_prescaler;
      end
   end

   // two instruction cycles without increment after a count write
   // counted in instruction ticks, so it also applies in counter mode
   always_comb begin
      next_holdoff = holdoff;
      if (wr_low) begin
         next_holdoff = WRITE_HOLDOFF; // RL8
      end else if (holdoff != 2'h0 && cycle_tick) begin
         next_holdoff = holdoff - 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         holdoff <= '0;
      end else begin
         holdoff <= next_holdoff;
      end
   end

   assign inc = (counter_control[CTL_BYPASS] ? src_tick : ps_tick) &&
                holdoff == 2'h0 && !wr_low; // RL5 RL7 RL8

   assign wrap = inc && count_low_byte == 8'hff &&
                 (counter_control[CTL_NARROW] || count_high_live == 8'hff); // RL13 RL18

   always_comb begin
      next_count_low = count_low_byte;
      if (wr_low) begin
         next_count_low = HWDATA[7:0];
      end else if (inc) begin
         next_count_low = count_low_byte + 8'h01; // RL2
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         count_low_byte <= '0;
      end else begin
         count_low_byte <= next_count_low;
      end
   end

   // live high byte, reached only through the buffer
   always_comb begin
      next_count_high = count_high_live;
      if (wr_low && !counter_control[CTL_NARROW]) begin
         next_count_high = high_byte_buffer; // RL16
      end else if (inc && !counter_control[CTL_NARROW] && count_low_byte == 8'hff) begin
         next_count_high = count_high_live + 8'h01; // RL18
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         count_high_live <= '0;
      end else begin
         count_high_live <= next_count_high;
      end
   end

   // a buffer write in its data phase beats a low read in its address phase
   always_comb begin
      next_buffer = high_byte_buffer;
      if (wr_buffer) begin
         next_buffer = HWDATA[7:0];
      end else if (rd_low && !counter_control[CTL_NARROW]) begin
         next_buffer = count_high_live; // RL15
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         high_byte_buffer <= HIGH_BUFFER_RESET;
      end else begin
         high_byte_buffer <= next_buffer;
      end
   end

   // set beats clear in the same cycle
   always_comb begin
      next_flag = overflow_flag;
      if (wrap) begin
         next_flag = 1'b1; // RL19
      end else if (wr_clear && HWDATA[0]) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         overflow_flag <= 1'b0;
      end else begin
         overflow_flag <= next_flag;
      end
   end

   assign IRQ = overflow_flag && overflow_irq_enable; // RL13
endmodule

/* bench/tmz_timer_assertions.sv */
`timescale 1ns/1ps
module tmz_timer_assertions
   import tmz_pkg::*;
(
   // clock, reset and bus requests
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   // block outputs
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic IRQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic tk;
   logic rd;
   logic wq;
   logic [11:0] aq;
   logic [7:0] ctl;
   assign tk = HSEL & HREADY & HTRANS[1];
   assign rd = tk & !HWRITE;
   always_ff @(posedge CORE_CLK) begin
      wq <= tk & HWRITE & !RST;
      aq <= HADDR;
   end
   // shadow of control; reads must give back what software wrote
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctl <= CONTROL_RESET;
      end else if (wq && aq == ADDR_CONTROL) begin
         ctl <= HWDATA[7:0];
      end
   end
   a_ready_high: assert property (HREADYOUT)
      else $error("ready dropped");
   a_resp_okay: assert property (!HRESP)
      else $error("error response");
   a_upper_zero: assert property (HRDATA[31:8] == 24'h0)
      else $error("upper read bits set");
   a_rdata_hold: assert property (!rd |=> $stable(HRDATA))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd && HADDR > ADDR_CYCLE_DIV |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_status_irq: assert property (rd && HADDR == ADDR_IRQ_STATUS && IRQ |=> HRDATA[0])
      else $error("irq high but flag clear");
   a_enable_irq: assert property (rd && HADDR == ADDR_IRQ_ENABLE && IRQ |=> HRDATA[0])
      else $error("irq high but enable clear");
   a_control_read: assert property (rd && HADDR == ADDR_CONTROL |=> HRDATA[7:0] == $past(ctl))
      else $error("control readback wrong");
   a_irq_fall: assert property ($fell(IRQ) |-> $past(wq)
      && ($past(aq) == ADDR_IRQ_CLEAR || $past(aq) == ADDR_IRQ_ENABLE))
      else $error("irq fell without clear or mask");
endmodule
bind tmz_timer tmz_timer_assertions chk_i (.CORE_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
   .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .IRQ);

/* bench/tmz_timer_bench.sv */
`timescale 1ns/1ps
module tmz_timer_bench;
   import tmz_pkg::*;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic HWRITE = 1'b0;
   logic [1:0] HTRANS = 2'h0;
   logic [11:0] HADDR = 12'h0;
   logic [31:0] HWDATA = 32'h0;
   logic EXT_COUNT_INPUT = 1'b0;
   logic SLEEP = 1'b0;
   logic [31:0] HRDATA;
   logic HREADYOUT;
   logic IRQ;
   logic [31:0] q;
   logic [31:0] v;
   int error_cnt = 0;
   int checks = 0;
   always #2 CORE_CLK = ~CORE_CLK;
   tmz_timer dut (.CORE_CLK, .RST, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
      .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP(), .EXT_COUNT_INPUT,
      .SLEEP, .IRQ);
   task give_verdict;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_rng(input logic [31:0] got, input int lo, input int hi);
      checks++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         error_cnt++;
         $display("[ERR] %0t got %h out of %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // one single word transfer; waits on ready rather than assuming zero wait
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      HADDR <= a;
      HWRITE <= w;
      HTRANS <= HTRANS_NONSEQ;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      HTRANS <= 2'h0;
      HWDATA <= d;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      q = HRDATA;
   endtask
   task rd16;
      xfer(1'b0, ADDR_COUNT_LOW, 0);
      v = q;
      xfer(1'b0, ADDR_HIGH_BUFFER, 0);
      v = {16'h0, q[7:0], v[7:0]};
   endtask
   task ld16(input logic [15:0] x);
      xfer(1'b1, ADDR_HIGH_BUFFER, {24'h0, x[15:8]});
      xfer(1'b1, ADDR_COUNT_LOW, {24'h0, x[7:0]});
   endtask
   task zz(input logic s);
      @(posedge CORE_CLK);
      SLEEP <= s;
   endtask
   task run(input int n);
      zz(1'b0);
      repeat (n) @(posedge CORE_CLK);
      zz(1'b1);
   endtask
   task t_rst;
      xfer(1'b0, ADDR_CONTROL, 0);
      chk(q, 32'hff);
      xfer(1'b0, ADDR_HIGH_BUFFER, 0);
      chk(q, 32'h0);
      xfer(1'b0, ADDR_IRQ_STATUS, 0);
      chk(q, 32'h0);
      xfer(1'b0, 12'h01c, 0);
      chk(q, 32'h0);
   endtask
   // four core clocks per instruction cycle; 4096 clocks is 1024 cycles
   task t_rates;
      int e;
      for (int i = 0; i < 9; i++) begin
         zz(1'b1);
         xfer(1'b1, ADDR_CONTROL, i < 8 ? 32'h80 | i : 32'h88);
         ld16(16'h0);
         run(4096);
         rd16;
         e = i < 8 ? 512 >> i : 1024;
         chk_rng(v, e - 2, e + 1);
      end
   endtask
   task t_psclr;
      xfer(1'b1, ADDR_CONTROL, 32'h87);
      ld16(16'h0);
      run(800);
      xfer(1'b1, ADDR_COUNT_LOW, 0);
      run(800);
      rd16;
      chk(v, 32'h0);
      zz(1'b0);
      xfer(1'b1, ADDR_CONTROL, 32'h8f);
      run(400);
      rd16;
      chk_rng(v, 95, 102);
      zz(1'b0);
      ld16(16'h0020);
      run(12);
      rd16;
      chk_rng(v, 32, 34);
   endtask
   task t_ext;
      for (int m = 0; m < 2; m++) begin
         zz(1'b1);
         EXT_COUNT_INPUT <= 1'b0;
         xfer(1'b1, ADDR_CONTROL, m ? 32'hb8 : 32'ha8);
         ld16(16'h0);
         zz(1'b0);
         repeat (12) @(posedge CORE_CLK);
         for (int k = 0; k < 9; k++) begin
            repeat (4) @(posedge CORE_CLK);
            EXT_COUNT_INPUT <= ~EXT_COUNT_INPUT;
         end
         run(8);
         rd16;
         chk(v, m ? 32'h4 : 32'h5);
      end
   endtask
   task t_ovf;
      xfer(1'b1, ADDR_CONTROL, 32'h88);
      ld16(16'hfffe);
      run(40);
      xfer(1'b0, ADDR_IRQ_STATUS, 0);
      chk(q, 32'h1);
      #1 chk(IRQ, 1'b0);
      rd16;
      chk_rng(v, 1, 8);
      xfer(1'b1, ADDR_IRQ_CLEAR, 1);
      xfer(1'b1, ADDR_CONTROL, 32'hc8);
      xfer(1'b1, ADDR_IRQ_ENABLE, 1);
      ld16(16'h55fc);
      run(40);
      #1 chk(IRQ, 1'b1);
      xfer(1'b0, ADDR_IRQ_ENABLE, 0);
      chk(q, 32'h1);
      xfer(1'b1, ADDR_CONTROL, 32'h88);
      rd16;
      chk(v[15:8], 8'h0);
      xfer(1'b1, ADDR_IRQ_ENABLE, 0);
      #1 chk(IRQ, 1'b0);
      xfer(1'b0, ADDR_IRQ_STATUS, 0);
      chk(q, 32'h1);
      xfer(1'b1, ADDR_IRQ_ENABLE, 1);
      #1 chk(IRQ, 1'b1);
      xfer(1'b0, ADDR_IRQ_STATUS, 0);
      chk(q, 32'h1);
      xfer(1'b1, ADDR_IRQ_CLEAR, 1);
      #1 chk(IRQ, 1'b0);
      xfer(1'b1, ADDR_CONTROL, 32'h08);
      ld16(16'h1234);
      run(40);
      rd16;
      chk(v, 32'h1234);
   endtask
   initial begin
      repeat (5) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_rst;
      t_rates;
      t_psclr;
      t_ext;
      t_ovf;
      give_verdict;
   end
   // normal run is about 40k clocks
   initial begin
      repeat (80000) @(posedge CORE_CLK);
      error_cnt++;
      give_verdict;
   end
endmodule
